// *** design/gsmc_core.sv ***
`timescale 1ns/1ps

// Contract
// - Command word 0x0041 at code 0x00 triggers a device reset pulse.
// - Command data arrives low byte first after the command code byte.
// - Command word 0x0020 at the control location enters sealed mode.
// - Seal sets both the full-access-restricted flag and the sealed flag.
// - Matching two-word unseal key moves sealed mode to unsealed.
// - Unsealing clears the sealed flag, keeps the full-access-restricted flag.
// - Full access key only accepted from unsealed mode.
// - Full access key is two words, default 0xFFFF each; clears restricted flag.
// - A sealed device powers back up sealed unless the default image is reloaded.
// - Power up in full access after the default image reload, or when the part was not sealed.
// - Keys are stored, changeable values; comparisons use the stored values.
// - Both flags are readable in the control status word.
// - Default configuration starts in full access with both flags clear.
module gsmc_core
   import gsmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        rx_valid,
   input  wire logic        rx_start,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_stop,
   input  wire logic        nv_sealed,
   input  wire logic        image_reload,
   input  wire logic        key_wr,
   input  wire logic [1:0]  key_idx,
   input  wire logic [15:0] key_data,
   output logic [15:0]      status_word,
   output logic             sealed_flag,
   output logic             full_access_restricted_flag,
   output logic             nv_seal_set,
   output logic             device_reset,
   output logic [2:0]       mode
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      gsmc_bstate_t bst;
      logic [7:0]   code;
      logic [7:0]   lo;
      gsmc_mode_t   mode;
      logic         key_pend;
      logic         cmp_go;
      logic [15:0]  cmp_word;
      logic         strap_done;
      logic         rst_pulse;
      logic         nv_set;
   } gsmc_state_t;

   gsmc_state_t s_q;
   gsmc_state_t s_d;
   logic [1:0]  rd_idx;
   logic [15:0] key_word;
   logic [15:0] word_in;
   logic        key_hit;

   // ==========================================================================
   // Key store
   // ==========================================================================
   // The compare stage looks up the stored key word a cycle ahead, so a key
   // word is judged one cycle after its high byte arrives. A key changed while
   // a pair is half entered is used from the next compare on.
   gsmc_key_mem #(
      .WIDTH   (16)
   ) u_keys (
      .clk     (clk),
      .reset   (reset),
      .wr_en   (key_wr),
      .wr_idx  (key_idx),
      .wr_data (key_data),
      .rd_idx  (rd_idx),
      .rd_data (key_word)
   );

   // ==========================================================================
   // Decode helpers
   // ==========================================================================
   // Picks the stored key word that the next data word is judged against:
   // the full access pair once unsealed, the unseal pair otherwise.
   function automatic logic [1:0] key_index(input gsmc_mode_t m, input logic hi);
      logic [1:0] base;
      base = (m == GSMC_UNSEALED) ? GSMC_KIDX_FULL_LO : GSMC_KIDX_UNSEAL_LO;
      return base | {1'b0, hi};
   endfunction : key_index

   // Mode taken on the first cycle after reset release. A part that was sealed
   // stays sealed across power loss unless the default image was reloaded.
   function automatic gsmc_mode_t power_up_mode(input logic was_sealed, input logic reload);
      gsmc_mode_t m;
      if (reload || !was_sealed) begin
         m = GSMC_FULL;
      end else begin
         m = GSMC_SEALED;
      end
      return m;
   endfunction : power_up_mode

   // One level up per accepted key pair; there is no path from sealed
   // straight to full access.
   function automatic gsmc_mode_t next_level(input gsmc_mode_t m);
      gsmc_mode_t n;
      case (m)
         GSMC_SEALED: begin
            n = GSMC_UNSEALED;
         end
         GSMC_UNSEALED: begin
            n = GSMC_FULL;
         end
         default: begin
            n = m;
         end
      endcase
      return n;
   endfunction : next_level

   // Status word: only the two security flags are defined, all else reads zero.
   function automatic logic [15:0] status_pack(input logic restr, input logic sealed);
      logic [15:0] w;
      w                 = 16'h0000;
      w[GSMC_RESTR_BIT] = restr;
      w[GSMC_SS_BIT]    = sealed;
      return w;
   endfunction : status_pack

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      s_d           = s_q;
      s_d.rst_pulse = 1'b0;
      s_d.nv_set    = 1'b0;
      s_d.cmp_go    = 1'b0;
      word_in       = {rx_byte, s_q.lo};
      rd_idx        = key_index(s_q.mode, s_q.key_pend);
      key_hit       = (s_q.cmp_word == key_word);

      // Power-up mode is caught after reset release, not under reset.
      if (!s_q.strap_done) begin
         s_d.strap_done = 1'b1;
         s_d.mode       = power_up_mode(nv_sealed, image_reload);
      end

      if (rx_valid) begin
         if (rx_start) begin
            s_d.bst  = GSMC_B_CODE;
            s_d.code = rx_byte;
         end else begin
            case (s_q.bst)
               GSMC_B_CODE: begin
                  s_d.lo  = rx_byte;
                  s_d.bst = GSMC_B_LOW;
               end
               GSMC_B_LOW: begin
                  s_d.bst = GSMC_B_HIGH;
                  if (s_q.code == GSMC_CTRL_CODE) begin
                     s_d.cmp_go   = 1'b1;
                     s_d.cmp_word = word_in;
                  end
               end
               default: begin
                  s_d.bst = GSMC_B_IDLE;
               end
            endcase
         end
      end
      // A stop ends any frame, so a cut frame never leaves the framer waiting
      // for the rest of a word that will not come.
      if (rx_stop) begin
         s_d.bst = GSMC_B_IDLE;
      end

      if (s_q.cmp_go) begin
         if (s_q.cmp_word == GSMC_CMD_RESET) begin
            s_d.rst_pulse = 1'b1;
            s_d.key_pend  = 1'b0;
         end else if (s_q.cmp_word == GSMC_CMD_SEAL && s_q.mode != GSMC_SEALED) begin
            s_d.mode     = GSMC_SEALED;
            s_d.nv_set   = 1'b1;
            s_d.key_pend = 1'b0;
         end else if (s_q.mode == GSMC_FULL || s_q.cmp_word == GSMC_CMD_STATUS) begin
            s_d.key_pend = 1'b0;
         end else if (!s_q.key_pend) begin
            s_d.key_pend = key_hit;
         end else begin
            s_d.key_pend = 1'b0;
            if (key_hit) begin
               s_d.mode = next_level(s_q.mode);
            end
         end
      end
   end

   // ==========================================================================
   // Register
   // ==========================================================================
   // Reset parks the part sealed until the power-up inputs have been looked
   // at, so nothing is granted while reset is high.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '{bst: GSMC_B_IDLE, mode: GSMC_SEALED, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   // The flags are decoded from the mode register rather than kept apart, so
   // they can never disagree with the mode that the key checks act on.
   assign sealed_flag                 = (s_q.mode == GSMC_SEALED);
   assign full_access_restricted_flag = (s_q.mode != GSMC_FULL);
   assign status_word = status_pack(full_access_restricted_flag, sealed_flag);
   assign nv_seal_set  = s_q.nv_set;
   assign device_reset = s_q.rst_pulse;
   assign mode         = s_q.mode;

endmodule : gsmc_core

// *** design/gsmc_key_mem.sv ***
`timescale 1ns/1ps

// ============================================================================
// Key store: four 16-bit words, registered read data.
// ============================================================================
module gsmc_key_mem
   import gsmc_pkg::*;
#(
   parameter int          WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             wr_en,
   input  wire logic [1:0]       wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [1:0]       rd_idx,
   output logic      [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem_q [GSMC_KEY_WORDS];

   always_ff @(posedge clk) begin
      if (reset) begin
         mem_q[GSMC_KIDX_UNSEAL_LO] <= GSMC_UNSEAL_KEY_RST[WIDTH-1:0];
         mem_q[GSMC_KIDX_UNSEAL_HI] <= GSMC_UNSEAL_KEY_RST[2*WIDTH-1:WIDTH];
         mem_q[GSMC_KIDX_FULL_LO]   <= GSMC_FULL_KEY_RST[WIDTH-1:0];
         mem_q[GSMC_KIDX_FULL_HI]   <= GSMC_FULL_KEY_RST[2*WIDTH-1:WIDTH];
         rd_data                    <= '0;
      end else begin
         if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
         end
         rd_data <= mem_q[rd_idx];
      end
   end

endmodule : gsmc_key_mem

// *** design/gsmc_pkg.sv ***
package gsmc_pkg;

   // ==========================================================================
   // Command location and access command values
   // ==========================================================================
   localparam logic [7:0]  GSMC_CTRL_CODE      = 8'h00;
   localparam logic [15:0] GSMC_CMD_RESET      = 16'h0041;
   localparam logic [15:0] GSMC_CMD_SEAL       = 16'h0020;
   localparam logic [15:0] GSMC_CMD_STATUS     = 16'h0000;

   // ==========================================================================
   // Default keys, each two words, first word sent in the low half
   // ==========================================================================
   localparam logic [31:0] GSMC_UNSEAL_KEY_RST = 32'h36720414;
   localparam logic [31:0] GSMC_FULL_KEY_RST   = 32'hFFFFFFFF;

   // ==========================================================================
   // Status word field positions
   // ==========================================================================
   localparam int          GSMC_SS_BIT         = 13;
   localparam int          GSMC_RESTR_BIT      = 14;
   localparam int          GSMC_RSTREQ_BIT     = 0;

   // ==========================================================================
   // Key store layout
   // ==========================================================================
   localparam int          GSMC_KEY_WORDS      = 4;
   localparam logic [1:0]  GSMC_KIDX_UNSEAL_LO = 2'h0;
   localparam logic [1:0]  GSMC_KIDX_UNSEAL_HI = 2'h1;
   localparam logic [1:0]  GSMC_KIDX_FULL_LO   = 2'h2;
   localparam logic [1:0]  GSMC_KIDX_FULL_HI   = 2'h3;

   typedef enum logic [2:0] {
      GSMC_SEALED   = 3'b001,
      GSMC_UNSEALED = 3'b010,
      GSMC_FULL     = 3'b100
   } gsmc_mode_t;

   typedef enum logic [3:0] {
      GSMC_B_IDLE = 4'b0001,
      GSMC_B_CODE = 4'b0010,
      GSMC_B_LOW  = 4'b0100,
      GSMC_B_HIGH = 4'b1000
   } gsmc_bstate_t;

endpackage : gsmc_pkg

// *** dv/gsmc_core_props.sv ***
`timescale 1ns/1ps

// ============================================================================
// Security mode checker
// ============================================================================
module gsmc_core_props
   import gsmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        rx_valid,
   input  wire logic        rx_start,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_stop,
   input  wire logic        nv_sealed,
   input  wire logic        image_reload,
   input  wire logic        key_wr,
   input  wire logic [1:0]  key_idx,
   input  wire logic [15:0] key_data,
   input  wire logic [15:0] status_word,
   input  wire logic        sealed_flag,
   input  wire logic        full_access_restricted_flag,
   input  wire logic        nv_seal_set,
   input  wire logic        device_reset,
   input  wire logic [2:0]  mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Code byte, then low and high data bytes on back-to-back cycles.
   sequence s_frame(logic [15:0] w);
      rx_valid && rx_start && rx_byte == GSMC_CTRL_CODE ##1 rx_valid && rx_byte == w[7:0]
      ##1 rx_valid && rx_byte == w[15:8];
   endsequence
   property p_reset; s_frame(GSMC_CMD_RESET) |-> ##2 device_reset; endproperty
   property p_seal; s_frame(GSMC_CMD_SEAL) |-> ##2 mode == GSMC_SEALED; endproperty
   property p_flags;
      sealed_flag == (mode == GSMC_SEALED) && full_access_restricted_flag == (mode != GSMC_FULL);
   endproperty
   property p_status; status_word == {1'b0, full_access_restricted_flag, sealed_flag, 13'h0}; endproperty
   property p_pulse; device_reset |=> !device_reset; endproperty
   property p_seal_note; $rose(sealed_flag) |-> nv_seal_set; endproperty
   property p_no_jump;
      mode == GSMC_FULL && $past(mode) != GSMC_FULL |-> $past(mode) == GSMC_UNSEALED || $past(reset, 2);
   endproperty
   property p_power;
      $fell(reset) && (image_reload || nv_sealed) |=> mode == ($past(image_reload) ? GSMC_FULL : GSMC_SEALED);
   endproperty
   a_reset: assert property (p_reset) else $error("reset command gave no pulse");
   a_seal: assert property (p_seal) else $error("seal command ignored");
   a_flags: assert property (p_flags) else $error("flags disagree with mode");
   a_status: assert property (p_status) else $error("status word wrong");
   a_pulse: assert property (p_pulse) else $error("reset pulse too long");
   a_seal_note: assert property (p_seal_note) else $error("seal not reported");
   a_no_jump: assert property (p_no_jump) else $error("full access not from unsealed");
   a_power: assert property (p_power) else $error("wrong power-up mode");
endmodule : gsmc_core_props

bind gsmc_core gsmc_core_props u_props (.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_start(rx_start),
   .rx_byte(rx_byte), .rx_stop(rx_stop), .nv_sealed(nv_sealed), .image_reload(image_reload), .key_wr(key_wr),
   .key_idx(key_idx), .key_data(key_data), .status_word(status_word), .sealed_flag(sealed_flag),
   .full_access_restricted_flag(full_access_restricted_flag), .nv_seal_set(nv_seal_set),
   .device_reset(device_reset), .mode(mode));

// *** dv/gsmc_host_model.sv ***
`timescale 1ns/1ps

// ============================================================================
// Host side: one command frame per call
// ============================================================================
module gsmc_host_model (
   input  wire logic       clk,
   output logic            rx_valid,
   output logic            rx_start,
   output logic [7:0]      rx_byte,
   output logic            rx_stop
);
   initial begin
      rx_valid = 1'b0;
      rx_start = 1'b0;
      rx_byte = 8'hA5;
      rx_stop = 1'b0;
   end
   // Returns at the edge where the command takes effect.
   task automatic send(input logic [7:0] code, input logic [15:0] w);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_start <= 1'b1;
      rx_byte <= code;
      @(posedge clk);
      rx_start <= 1'b0;
      rx_byte <= w[7:0];
      @(posedge clk);
      rx_byte <= w[15:8];
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_stop <= 1'b1;
      // A released data line must not keep looking like valid data.
      rx_byte <= ~w[15:8];
      @(posedge clk);
      rx_stop <= 1'b0;
   endtask : send
endmodule : gsmc_host_model

// *** dv/tb_gsmc_core.sv ***
`timescale 1ns/1ps

// ============================================================================
// Security mode testbench
// ============================================================================
module tb_gsmc_core import gsmc_pkg::*; ();
   typedef struct packed {logic [7:0] c; logic [15:0] w; logic [2:0] m;} gsmc_row_t;
   logic        clk = 1'b0, reset = 1'b1, nv_sealed = 1'b0, image_reload = 1'b1, key_wr = 1'b0;
   logic [1:0]  key_idx = 2'h0;
   logic [15:0] key_data = 16'h0000, status_word;
   logic        rx_valid, rx_start, rx_stop, sealed_flag, full_access_restricted_flag, nv_seal_set, device_reset;
   logic [7:0]  rx_byte;
   logic [2:0]  mode;
   int          mismatches = 0, checked = 0;
   gsmc_row_t   rows[11] = '{'{8'h00,16'h0000,GSMC_FULL}, '{8'h05,16'h0020,GSMC_FULL},
      '{8'h00,16'h0020,GSMC_SEALED}, '{8'h00,16'h0414,GSMC_SEALED}, '{8'h00,16'h1234,GSMC_SEALED},
      '{8'h00,16'hFFFF,GSMC_SEALED}, '{8'h00,16'hFFFF,GSMC_SEALED}, '{8'h00,16'h0414,GSMC_SEALED},
      '{8'h00,16'h3672,GSMC_UNSEALED}, '{8'h00,16'hFFFF,GSMC_UNSEALED}, '{8'h00,16'hFFFF,GSMC_FULL}};
   always #5 clk = ~clk;
   gsmc_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_start(rx_start), .rx_byte(rx_byte), .rx_stop(rx_stop));
   gsmc_core u_dut (.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_start(rx_start), .rx_byte(rx_byte),
      .rx_stop(rx_stop), .nv_sealed(nv_sealed), .image_reload(image_reload), .key_wr(key_wr), .key_idx(key_idx),
      .key_data(key_data), .status_word(status_word), .sealed_flag(sealed_flag),
      .full_access_restricted_flag(full_access_restricted_flag), .nv_seal_set(nv_seal_set),
      .device_reset(device_reset), .mode(mode));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checked++;
      if (e !== s) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic chk_mode(input logic [2:0] m);
      chk("mode", {13'h0, m}, {13'h0, mode});
      chk("status_word", {1'b0, m != GSMC_FULL, m == GSMC_SEALED, 13'h0}, status_word);
      chk("sealed_flag", {15'h0, m == GSMC_SEALED}, {15'h0, sealed_flag});
      chk("full_access_restricted_flag", {15'h0, m != GSMC_FULL}, {15'h0, full_access_restricted_flag});
   endtask : chk_mode
   task automatic do_reset(input logic nv, input logic img);
      @(posedge clk);
      reset <= 1'b1;
      nv_sealed <= nv;
      image_reload <= img;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : do_reset
   task automatic key_write(input logic [1:0] i, input logic [15:0] d);
      @(posedge clk);
      key_wr <= 1'b1;
      key_idx <= i;
      key_data <= d;
      @(posedge clk);
      key_wr <= 1'b0;
   endtask : key_write
   task automatic frame(input logic [15:0] w, input logic [2:0] m);
      u_host.send(GSMC_CTRL_CODE, w);
      #1;
      chk_mode(m);
   endtask : frame
   task automatic summarize();
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   initial begin
      #50000;
      mismatches++;
      summarize();
   end
   initial begin
      do_reset(1'b0, 1'b1);
      chk_mode(GSMC_FULL);
      foreach (rows[i]) begin
         u_host.send(rows[i].c, rows[i].w);
         #1;
         chk_mode(rows[i].m);
      end
      u_host.send(GSMC_CTRL_CODE, GSMC_CMD_RESET);
      #1;
      chk("device_reset", 16'h0001, {15'h0, device_reset});
      chk_mode(GSMC_FULL);
      key_write(GSMC_KIDX_UNSEAL_LO, 16'h1111);
      key_write(GSMC_KIDX_UNSEAL_HI, 16'h2222);
      frame(GSMC_CMD_SEAL, GSMC_SEALED);
      chk("nv_seal_set", 16'h0001, {15'h0, nv_seal_set});
      frame(16'h0414, GSMC_SEALED);
      frame(16'h3672, GSMC_SEALED);
      frame(16'h1111, GSMC_SEALED);
      frame(16'h2222, GSMC_UNSEALED);
      do_reset(1'b1, 1'b0);
      chk_mode(GSMC_SEALED);
      summarize();
   end
endmodule : tb_gsmc_core
